// ==== hw/cir_top.sv ====
`timescale 1ns/1ps
// Operation
// (R1) three cascaded controllers give 22 levels
// (R2) first slave feeds master input two
// (R3) second slave feeds master input five
// (R4) 16 internal plus 15 external sources
// (R5) externals have edge/level and polarity
// (R6) crossbar routes any source to level
// (R7) any source may route to NMI
// (R8) bypass feeds master input from crossbar
module cir_top
  import cir_pkg::*;
#(
  parameter int N_EXT = cir_pkg::CIR_EXT
) (
  input  wire logic                         CLK,
  input  wire logic                         NRST,
  input  wire logic                         HSEL,
  input  wire logic [31:0]                  HADDR,
  input  wire logic [1:0]                   HTRANS,
  input  wire logic                         HWRITE,
  input  wire logic [2:0]                   HSIZE,
  input  wire logic [31:0]                  HWDATA,
  input  wire logic                         HREADY,
  output logic      [31:0]                  HRDATA,
  output logic                              HREADYOUT,
  output logic                              HRESP,
  input  wire logic [cir_pkg::CIR_INT-1:0]  INT_SRC,
  input  wire logic [N_EXT-1:0]             EXT_IRQ,
  output logic                              CPU_INTR,
  output logic                              CPU_NMI
);
  import cir_pkg::*;

  localparam int N_SRC = CIR_INT + N_EXT;

  if (N_EXT < 1 || N_EXT > CIR_EXT) begin : g_chk
    $error("cir_top: N_EXT must be 1 to 15");
  end

  typedef struct packed {
    cir_bus_e                      bst;
    logic [CIR_AW-1:0]             addr;
    logic                          wr;
    logic                          ready;
    logic [31:0]                   rdata;
    logic [1:0]                    byp;
    logic [2:0][7:0]               mask;
    logic [N_EXT-1:0]              edge_sel;
    logic [N_EXT-1:0]              pol;
    logic [N_EXT-1:0]              eclr;
    logic [N_SRC-1:0][CIR_RW-1:0]  route;
    logic [2:0]                    ack;
    logic [2:0][7:0]               eoi;
    logic                          intr;
    logic                          nmi;
  } cir_top_s;

  cir_top_s s_r;
  cir_top_s s_nxt;

  logic [N_EXT-1:0]       ext_lvl;
  logic [N_SRC-1:0]       src_lvl;
  logic [CIR_LINES:0]     xbar;
  logic [31:0]            ack_word;
  logic [2:0]             ack_hit;
  logic [CIR_RW-1:0]      route_idx;
  logic [1:0]             mask_idx;
  logic [4:0]             eoi_line;

  cir_pic_if pm ();
  cir_pic_if ps1 ();
  cir_pic_if ps2 ();

  // (R4) external pins conditioned, internals on this clock
  cir_ext_cond #(
    .N        (N_EXT)
  ) u_ext (
    .clk      (CLK),
    .nrst     (NRST),
    .pin      (EXT_IRQ),
    .edge_sel (s_r.edge_sel),
    .pol      (s_r.pol),
    .clr      (s_r.eclr),
    .lvl      (ext_lvl)
  );

  // (R4) sources 0..15 internal, 16 up external
  assign src_lvl = {ext_lvl, INT_SRC};

  // one line per controller input plus the nmi column
  function automatic logic [CIR_LINES:0] cir_xbar(
    input logic [N_SRC-1:0][CIR_RW-1:0] rt,
    input logic [N_SRC-1:0]             lv
  );
    logic [CIR_LINES:0] o;
    o = '0;
    for (int i = 0; i < N_SRC; i++) begin
      if (lv[i] && rt[i] != ROUTE_NONE && rt[i] <= ROUTE_NMI) begin
        o[rt[i] - 5'h01] = 1'b1;
      end
    end
    return o;
  endfunction : cir_xbar

  // (R6) route sources onto controller lines
  assign xbar = cir_xbar(s_r.route, src_lvl);

  // (R1) master plus two slaves
  cir_pic u_master (.clk(CLK), .nrst(NRST), .p(pm.pic));
  cir_pic u_slave1 (.clk(CLK), .nrst(NRST), .p(ps1.pic));
  cir_pic u_slave2 (.clk(CLK), .nrst(NRST), .p(ps2.pic));

  always_comb begin
    pm.req = xbar[7:0];
    // (R2) first slave on master input two
    // (R8) bypass takes the crossbar line
    pm.req[MASTER_IN_TWO]  = s_r.byp[CTRL_BYP1] ? xbar[MASTER_IN_TWO] : ps1.irq;
    // (R3) second slave on master input five
    // (R8) bypass takes the crossbar line
    pm.req[MASTER_IN_FIVE] = s_r.byp[CTRL_BYP2] ? xbar[MASTER_IN_FIVE] : ps2.irq;
  end

  assign pm.imr  = s_r.mask[0];
  assign pm.ack  = s_r.ack[0];
  assign pm.eoi  = s_r.eoi[0];
  assign ps1.req = xbar[15:8];
  assign ps1.imr = s_r.mask[1];
  assign ps1.ack = s_r.ack[1];
  assign ps1.eoi = s_r.eoi[1];
  assign ps2.req = xbar[23:16];
  assign ps2.imr = s_r.mask[2];
  assign ps2.ack = s_r.ack[2];
  assign ps2.eoi = s_r.eoi[2];

  // acknowledge read: resolve the cascade to one line
  always_comb begin
    ack_word = DATA_ZERO;
    ack_hit  = 3'b000;
    if (pm.irq) begin
      ack_word[ACK_VALID] = 1'b1;
      ack_hit[0]          = 1'b1;
      if (pm.sel == MASTER_IN_TWO && !s_r.byp[CTRL_BYP1]) begin
        // (R2) cascade into first slave
        ack_word[4:0] = {2'b01, ps1.sel};
        ack_hit[1]    = 1'b1;
      end else if (pm.sel == MASTER_IN_FIVE && !s_r.byp[CTRL_BYP2]) begin
        // (R3) cascade into second slave
        ack_word[4:0] = {2'b10, ps2.sel};
        ack_hit[2]    = 1'b1;
      end else begin
        ack_word[4:0] = {2'b00, pm.sel};
      end
    end
  end

  // decode shared by the read and write paths
  function automatic logic cir_is_mask(input logic [CIR_AW-1:0] a);
    return a >= OFS_MASK0 && a <= OFS_MASK2 && a[1:0] == 2'b00;
  endfunction : cir_is_mask

  function automatic logic cir_is_route(input logic [CIR_AW-1:0] a);
    logic [CIR_AW-1:0] o;
    o = a - OFS_ROUTE;
    return a >= OFS_ROUTE && a[1:0] == 2'b00 && o < CIR_AW'(4 * N_SRC);
  endfunction : cir_is_route

  assign route_idx = CIR_RW'((s_r.addr - OFS_ROUTE) >> 2);
  assign mask_idx  = 2'((s_r.addr - OFS_MASK0) >> 2);
  assign eoi_line  = HWDATA[4:0];

  always_comb begin
    s_nxt      = s_r;
    s_nxt.ack  = 3'b000;
    s_nxt.eoi  = '0;
    s_nxt.eclr = '0;
    s_nxt.intr = pm.irq;
    // (R7) nmi column ored from any routed source
    s_nxt.nmi  = xbar[CIR_LINES];
    unique case (s_r.bst)
      CIR_B_IDLE: begin
        if (HSEL && HREADY && HTRANS[1]) begin
          s_nxt.bst   = CIR_B_BUSY;
          s_nxt.addr  = HADDR[CIR_AW-1:0];
          s_nxt.wr    = HWRITE;
          s_nxt.ready = 1'b0;
        end
      end
      CIR_B_BUSY: begin
        // one wait state so read data leave a flop
        s_nxt.bst   = CIR_B_IDLE;
        s_nxt.ready = 1'b1;
        s_nxt.rdata = DATA_ZERO;
        if (s_r.wr) begin
          if (s_r.addr == OFS_CTRL) begin
            s_nxt.byp = HWDATA[1:0];
          end else if (cir_is_mask(s_r.addr)) begin
            s_nxt.mask[mask_idx] = HWDATA[7:0];
          end else if (s_r.addr == OFS_EDGE) begin
            // (R5) edge or level per pin
            s_nxt.edge_sel = HWDATA[N_EXT-1:0];
          end else if (s_r.addr == OFS_POL) begin
            // (R5) active polarity per pin
            s_nxt.pol = HWDATA[N_EXT-1:0];
          end else if (s_r.addr == OFS_EXT) begin
            s_nxt.eclr = HWDATA[N_EXT-1:0];
          end else if (s_r.addr == OFS_EOI && eoi_line < 5'(CIR_LINES)) begin
            s_nxt.eoi[eoi_line[4:3]][eoi_line[2:0]] = 1'b1;
            // a slave eoi also frees its master input
            if (eoi_line[4:3] == 2'b01 && !s_r.byp[CTRL_BYP1]) begin
              s_nxt.eoi[0][MASTER_IN_TWO] = 1'b1;
            end
            if (eoi_line[4:3] == 2'b10 && !s_r.byp[CTRL_BYP2]) begin
              s_nxt.eoi[0][MASTER_IN_FIVE] = 1'b1;
            end
          end else if (cir_is_route(s_r.addr)) begin
            // (R6) (R7) one code per source
            s_nxt.route[route_idx] = HWDATA[CIR_RW-1:0];
          end
        end else begin
          if (s_r.addr == OFS_CTRL) begin
            s_nxt.rdata[1:0] = s_r.byp;
          end else if (cir_is_mask(s_r.addr)) begin
            s_nxt.rdata[7:0] = s_r.mask[mask_idx];
          end else if (s_r.addr == OFS_EDGE) begin
            s_nxt.rdata[N_EXT-1:0] = s_r.edge_sel;
          end else if (s_r.addr == OFS_POL) begin
            s_nxt.rdata[N_EXT-1:0] = s_r.pol;
          end else if (s_r.addr == OFS_EXT) begin
            s_nxt.rdata[N_EXT-1:0] = ext_lvl;
          end else if (s_r.addr == OFS_STATUS) begin
            s_nxt.rdata[CIR_LINES-1:0] = xbar[CIR_LINES-1:0];
            s_nxt.rdata[STAT_INTR]     = s_r.intr;
            s_nxt.rdata[STAT_NMI]      = s_r.nmi;
          end else if (s_r.addr == OFS_ACK) begin
            // reading acknowledges; no request reads zero
            s_nxt.rdata = ack_word;
            s_nxt.ack   = ack_hit;
          end else if (cir_is_route(s_r.addr)) begin
            s_nxt.rdata[CIR_RW-1:0] = s_r.route[route_idx];
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_r       <= '0;
      s_r.bst   <= CIR_B_IDLE;
      s_r.ready <= 1'b1;
      s_r.mask  <= {3{MASK_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // data, ready and cpu outputs leave flops; response is tied to okay
  assign HRDATA    = s_r.rdata;
  assign HREADYOUT = s_r.ready;
  assign HRESP     = 1'b0;
  assign CPU_INTR  = s_r.intr;
  assign CPU_NMI   = s_r.nmi;
endmodule : cir_top

// ==== hw/cir_pkg.sv ====
package cir_pkg;

  // source and level counts
  localparam int CIR_INT     = 16;
  localparam int CIR_EXT     = 15;
  localparam int CIR_SRC     = 31;
  localparam int CIR_LEVELS  = 22;
  localparam int CIR_LINES   = 24;
  localparam int CIR_RW      = 5;

  // route codes: 0 off, 1..24 controller line plus one, 25 non-maskable
  localparam logic [CIR_RW-1:0] ROUTE_NONE = 5'h00;
  localparam logic [CIR_RW-1:0] ROUTE_NMI  = 5'h19;

  // master lines fed by the slaves
  localparam logic [2:0] MASTER_IN_TWO  = 3'h2;
  localparam logic [2:0] MASTER_IN_FIVE = 3'h5;

  // register byte offsets
  localparam int          CIR_AW      = 12;
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_MASK0   = 12'h004;
  localparam logic [11:0] OFS_MASK2   = 12'h00c;
  localparam logic [11:0] OFS_EDGE    = 12'h010;
  localparam logic [11:0] OFS_POL     = 12'h014;
  localparam logic [11:0] OFS_EXT     = 12'h018;
  localparam logic [11:0] OFS_STATUS  = 12'h01c;
  localparam logic [11:0] OFS_ACK     = 12'h020;
  localparam logic [11:0] OFS_EOI     = 12'h024;
  localparam logic [11:0] OFS_ROUTE   = 12'h080;

  // field positions and reset values
  localparam int          CTRL_BYP1   = 0;
  localparam int          CTRL_BYP2   = 1;
  localparam int          STAT_INTR   = 24;
  localparam int          STAT_NMI    = 25;
  localparam int          ACK_VALID   = 31;
  localparam logic [7:0]  MASK_RST    = 8'hff;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    CIR_B_IDLE = 2'b01,
    CIR_B_BUSY = 2'b10
  } cir_bus_e;

endpackage : cir_pkg

// ==== hw/cir_pic_if.sv ====
`timescale 1ns/1ps
interface cir_pic_if;
  logic [7:0] req;
  logic [7:0] imr;
  logic [7:0] eoi;
  logic       ack;
  logic       irq;
  logic [2:0] sel;

  modport ctl (output req, output imr, output eoi, output ack, input irq, input sel);
  modport pic (input req, input imr, input eoi, input ack, output irq, output sel);
endinterface : cir_pic_if

// ==== hw/cir_pic.sv ====
`timescale 1ns/1ps
module cir_pic (
  input wire logic clk,
  input wire logic nrst,
  cir_pic_if.pic   p
);
  import cir_pkg::*;

  typedef struct packed {
    logic [7:0] isr;
    logic       irq;
    logic [2:0] sel;
  } cir_pic_s;

  cir_pic_s s_r;
  cir_pic_s s_nxt;
  logic [7:0] pend;
  logic [3:0] first_pend;

  // lowest index wins, 8 when empty
  function automatic logic [3:0] cir_first(input logic [7:0] v);
    logic [3:0] f;
    f = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) f = 4'(i);
    end
    return f;
  endfunction : cir_first

  assign pend  = p.req & ~p.imr;
  assign first_pend = cir_first(pend);
  assign p.irq = s_r.irq;
  assign p.sel = s_r.sel;

  always_comb begin
    s_nxt = s_r;
    // ack marks the line software was shown
    if (p.ack) s_nxt.isr[s_r.sel] = 1'b1;
    s_nxt.isr = s_nxt.isr & ~p.eoi;
    // empty pend gives 8, whose low bits are line 0
    s_nxt.sel = first_pend[2:0];
    // next isr used so a second ack never sees a stale request
    s_nxt.irq = (pend != 8'h00) && (first_pend < cir_first(s_nxt.isr));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) s_r <= '0;
    else       s_r <= s_nxt;
  end
endmodule : cir_pic

// ==== hw/cir_ext_cond.sv ====
`timescale 1ns/1ps
module cir_ext_cond #(
  parameter int N = 15
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] edge_sel,
  input  wire logic [N-1:0] pol,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] lvl
);
  import cir_pkg::*;

  if (N < 1 || N > 32) begin : g_chk
    $error("cir_ext_cond: N out of range");
  end

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] act_d;
    logic [N-1:0] latch;
    logic [N-1:0] lvl;
  } cir_ext_s;

  cir_ext_s s_r;
  cir_ext_s s_nxt;
  logic [N-1:0] act;

  // (R5) polarity then sense
  assign act = ~(s_r.sync2 ^ pol);
  assign lvl = s_r.lvl;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.act_d = act;
    // set beats a same-cycle clear
    s_nxt.latch = (s_r.latch & ~clr) | (act & ~s_r.act_d);
    // (R5) edge or level select
    s_nxt.lvl   = (edge_sel & s_nxt.latch) | (~edge_sel & act);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // low sync reads active under reset polarity; no false edge
      s_r       <= '0;
      s_r.act_d <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : cir_ext_cond

// ==== verif/cir_top_chk.sv ====
`timescale 1ns/1ps
module cir_top_chk
  import cir_pkg::*;
(
  input logic        CLK,
  input logic        NRST,
  input logic        HSEL,
  input logic [31:0] HADDR,
  input logic [1:0]  HTRANS,
  input logic        HWRITE,
  input logic [31:0] HWDATA,
  input logic        HREADY,
  input logic [31:0] HRDATA,
  input logic        HREADYOUT,
  input logic        HRESP,
  input logic [15:0] INT_SRC,
  input logic        CPU_INTR,
  input logic        CPU_NMI
);
  typedef struct packed {
    logic        ph;
    logic        pw;
    logic [11:0] pa;
    logic [15:0] nm;
    logic [7:0]  m0;
    logic        er;
  } cir_chk_s;
  cir_chk_s st_r;
  cir_chk_s st_nxt;
  logic     take;
  logic     wr_d;
  logic     nmi_due;
  assign take = HSEL && HREADY && HTRANS[1];
  assign wr_d = st_r.ph && st_r.pw;
  assign nmi_due = |(INT_SRC & st_r.nm);
  // shadow of bus writes, updated on the slave's own edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.ph = take;
    if (take) begin
      st_nxt.pa = HADDR[11:0];
      st_nxt.pw = HWRITE;
    end
    if (wr_d && st_r.pa == OFS_MASK0) begin
      st_nxt.m0 = HWDATA[7:0];
    end
    if (wr_d && st_r.pa[11:6] == 6'h02) begin
      st_nxt.nm[st_r.pa[5:2]] = HWDATA[4:0] == ROUTE_NMI;
    end
    // external routes make the source check unsound, so it stops
    if (wr_d && st_r.pa[11:6] == 6'h03 && HWDATA[4:0] != ROUTE_NONE) begin
      st_nxt.er = 1'b1;
    end
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '{m0: MASK_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  a_wait_one: assert property (take && HREADYOUT |=> !HREADYOUT ##1 HREADYOUT)
    else $error("data phase not two cycles");
  a_wait_cause: assert property (!HREADYOUT |-> $past(take))
    else $error("wait state without transfer");
  a_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
    else $error("read data moved while idle");
  a_nmi_route: assert property (nmi_due |=> CPU_NMI)
    else $error("routed source gave no nmi");
  a_intr_masked: assert property ((st_r.m0 == 8'hff) [*3] |-> !CPU_INTR)
    else $error("interrupt with master fully masked");
  a_reset_quiet: assert property ($rose(NRST) |-> !CPU_INTR && !CPU_NMI)
    else $error("outputs active after reset");
  a_intr_cause: assert property ($rose(CPU_INTR) && !st_r.er |-> $past(INT_SRC, 2) != 0 || $past(INT_SRC, 3) != 0)
    else $error("interrupt without active source");
endmodule : cir_top_chk
bind cir_top cir_top_chk u_cir_top_chk (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .INT_SRC(INT_SRC), .CPU_INTR(CPU_INTR), .CPU_NMI(CPU_NMI));

// ==== verif/cir_far_model.sv ====
`timescale 1ns/1ps
module cir_far_model #(
  parameter int N = 15
) (
  input  logic         clk,
  input  logic         nrst,
  input  logic [N-1:0] act,
  input  logic [N-1:0] pol,
  input  logic         cpu_nmi,
  output logic [N-1:0] pins,
  output int unsigned  nmi_seen
);
  logic nmi_q;
  assign pins = act ~^ pol;
  // core takes each nmi rise once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nmi_q <= 1'b0;
      nmi_seen <= 0;
    end else begin
      nmi_q <= cpu_nmi;
      if (cpu_nmi && !nmi_q) begin
        nmi_seen <= nmi_seen + 1;
      end
    end
  end
endmodule : cir_far_model

// ==== verif/cir_top_tb.sv ====
`timescale 1ns/1ps
module cir_top_tb;
  import cir_pkg::*;
  typedef struct packed {
    logic [4:0] s;
    logic [4:0] c;
  } cir_row_s;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0000_0000;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic [15:0] INT_SRC = 16'h0000;
  logic [14:0] act = 15'h0000;
  logic [14:0] ppol = 15'h0000;
  logic [14:0] ext;
  logic        CPU_INTR;
  logic        CPU_NMI;
  int unsigned nmi_seen;
  int          failures = 0;
  int          tests_run = 0;
  logic [31:0] r;
  cir_row_s    rows [9] = '{'{5'h00, 5'h01}, '{5'h03, 5'h05}, '{5'h07, 5'h08}, '{5'h09, 5'h09},
    '{5'h0c, 5'h10}, '{5'h0f, 5'h11}, '{5'h05, 5'h18}, '{5'h02, 5'h19}, '{5'h10, 5'h01}};
  always #2 CLK = ~CLK;
  cir_top u_cir_top (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(),
    .INT_SRC(INT_SRC), .EXT_IRQ(ext), .CPU_INTR(CPU_INTR), .CPU_NMI(CPU_NMI));
  cir_far_model u_cir_far_model (.clk(CLK), .nrst(NRST), .act(act), .pol(ppol), .cpu_nmi(CPU_NMI),
    .pins(ext), .nmi_seen(nmi_seen));
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  // waits end on hready; a hung slave ends the run
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {20'h0_0000, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1 && ++n < 20);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1 && ++n < 20);
    r = HRDATA;
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
  endtask : bus
  task automatic wait_hi(input logic nmi);
    int n;
    n = 0;
    while ((nmi ? CPU_NMI : CPU_INTR) !== 1'b1 && n < 40) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 40) begin
      failures++;
      give_verdict();
    end
  endtask : wait_hi
  task automatic srcset(input int s, input logic v);
    @(posedge CLK);
    if (s < 16) INT_SRC[s] <= v;
    else act[s-16] <= v;
  endtask : srcset
  task automatic do_case(input int s, input logic [4:0] c);
    bus(1'b1, OFS_ROUTE + 12'(4 * s), {27'h0, c});
    srcset(s, 1'b1);
    wait_hi(c == ROUTE_NMI);
    if (c != ROUTE_NMI) begin
      bus(1'b0, OFS_ACK, 32'h0000_0000);
      chk("ack", 32'h8000_0000 + 32'(c - 5'h01), r);
      bus(1'b1, OFS_EOI, 32'(c - 5'h01));
    end
    srcset(s, 1'b0);
    bus(1'b1, OFS_ROUTE + 12'(4 * s), 32'h0000_0000);
  endtask : do_case
  initial begin
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    bus(1'b0, OFS_MASK0, 32'h0000_0000);
    chk("mask reset", 32'h0000_00ff, r);
    bus(1'b0, OFS_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, r);
    bus(1'b0, 12'h040, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, r);
    for (int i = 0; i < 3; i++) bus(1'b1, OFS_MASK0 + 12'(4 * i), 32'h0000_0000);
    for (int i = 0; i < 9; i++) do_case(int'(rows[i].s), rows[i].c);
    chk("nmi count", 32'h0000_0001, 32'(nmi_seen));
    bus(1'b1, OFS_CTRL, 32'h0000_0003);
    do_case(1, 5'h03);
    do_case(1, 5'h06);
    // bypassed slave must not reach the master
    bus(1'b1, OFS_ROUTE + 12'h004, 32'h0000_0009);
    srcset(1, 1'b1);
    repeat (8) @(posedge CLK);
    chk("bypassed intr", 32'h0000_0000, {31'h0, CPU_INTR});
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0100, r);
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    wait_hi(1'b0);
    bus(1'b0, OFS_ACK, 32'h0000_0000);
    chk("cascade ack", 32'h8000_0008, r);
    bus(1'b1, OFS_EOI, 32'h0000_0008);
    srcset(1, 1'b0);
    // edge latch holds a short rising pulse until cleared
    bus(1'b1, OFS_EDGE, 32'h0000_0001);
    bus(1'b1, OFS_POL, 32'h0000_0001);
    ppol <= 15'h0001;
    // polarity flip and the earlier level case on source 16 leave the latch set
    bus(1'b1, OFS_EXT, 32'h0000_0001);
    bus(1'b1, OFS_ROUTE + 12'h040, 32'h0000_0001);
    srcset(16, 1'b1);
    repeat (4) @(posedge CLK);
    srcset(16, 1'b0);
    wait_hi(1'b0);
    repeat (10) @(posedge CLK);
    chk("edge latch", 32'h0000_0001, {31'h0, CPU_INTR});
    bus(1'b0, OFS_ACK, 32'h0000_0000);
    chk("edge ack", 32'h8000_0000, r);
    bus(1'b1, OFS_EXT, 32'h0000_0001);
    bus(1'b1, OFS_EOI, 32'h0000_0000);
    repeat (6) @(posedge CLK);
    chk("latch cleared", 32'h0000_0000, {31'h0, CPU_INTR});
    give_verdict();
  end
endmodule : cir_top_tb
